// [hw/bcs_top.sv]
// Bridge control and host scratch register bank behind the serial register port.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"

module bcs_top
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic restart,
    input wire logic normal_mode,
    input wire bcs_pkg::bcs_req_t req,
    output bcs_pkg::bcs_resp_t resp,
    output bcs_pkg::bcs_bridge_cfg_t bridge_cfg,
    output logic [15:0] scratch_value
);
    import bcs_pkg::*;

    bcs_top_state_t st_r;
    bcs_top_state_t st_nxt;

    logic hit_ctrl;
    logic hit_scratch;
    logic scratch_open;
    logic ctrl_wr;
    logic scratch_wr;
    logic [15:0] ctrl_q;
    logic [15:0] scratch_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_scratch = 1'b0;
        if (req.addr == `BCS_ADDR_GENERAL_BRIDGE_CONTROL)
        begin
            hit_ctrl = 1'b1;
        end
        else if (req.addr == `BCS_ADDR_SCRATCH)
        begin
            hit_scratch = 1'b1;
        end
    end

    assign scratch_open = hit_scratch && normal_mode;
    // A control write that meets soft reset or restart is lost, so it is not echoed either; a scratch write is lost only to soft reset.
    assign ctrl_wr = req.valid && req.write && hit_ctrl && !soft_rst && !restart;
    assign scratch_wr = req.valid && req.write && scratch_open && !soft_rst;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Scratch restart input is tied low, so restart and fail-safe keep it.
    bcs_hold_reg
    #(
        .WIDTH(`BCS_DATA_W),
        .RST_VAL(`BCS_SCRATCH_RST),
        .WR_MASK(`BCS_SCRATCH_WMASK)
    )
    u_scratch
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .soft_rst(soft_rst),
        .restart(1'b0),
        .wr_en(scratch_wr),
        .wr_data(req.wdata),
        .q(scratch_q)
    );

    bcs_hold_reg
    #(
        .WIDTH(`BCS_DATA_W),
        .RST_VAL(`BCS_GENERAL_BRIDGE_CONTROL_RST),
        .WR_MASK(`BCS_GENERAL_BRIDGE_CONTROL_WMASK)
    )
    u_general_bridge_control
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .soft_rst(soft_rst),
        .restart(restart),
        .wr_en(ctrl_wr),
        .wr_data(req.wdata),
        .q(ctrl_q)
    );

    // ----------------------------------------------------------------
    // Access response
    // ----------------------------------------------------------------
    // Refused scratch accesses outside Normal Mode read back as zero.
    always_comb
    begin
        st_nxt = '0;
        if (req.valid)
        begin
            st_nxt.resp.ack = 1'b1;
            if (hit_ctrl)
            begin
                st_nxt.resp.rdata = ctrl_wr ? (req.wdata & `BCS_GENERAL_BRIDGE_CONTROL_WMASK) : ctrl_q;
            end
            else if (scratch_open)
            begin
                st_nxt.resp.rdata = scratch_wr ? req.wdata : scratch_q;
            end
            else if (hit_scratch)
            begin
                st_nxt.resp.refused = 1'b1;
            end
            else
            begin
                st_nxt.resp.unmapped = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Settings to the bridge driver
    // ----------------------------------------------------------------
    assign resp = st_r.resp;
    assign scratch_value = scratch_q;
    assign bridge_cfg.sync_freq_select = ctrl_q[`BCS_POS_SYNC_FREQ];
    assign bridge_cfg.pump_undervolt_threshold = ctrl_q[`BCS_POS_UV_TH];
    assign bridge_cfg.mosfet_level_select = ctrl_q[`BCS_POS_MOSFET_LEVEL_SELECT];
    assign bridge_cfg.pump_stage_autoswitch = ctrl_q[`BCS_POS_STAGE_AUTO];
    assign bridge_cfg.overvolt_recovery_enable = ctrl_q[`BCS_POS_OV_REC];
    assign bridge_cfg.precurrent_step_size = ctrl_q[`BCS_POS_STEP_SIZE];
    assign bridge_cfg.adaptive_gate_mode =
        bcs_agc_mode_t'(ctrl_q[`BCS_POS_AGC_HI:`BCS_POS_AGC_LO]);
    assign bridge_cfg.pump_enable = ctrl_q[`BCS_POS_PUMP_EN];
    assign bridge_cfg.postcharge_disable = ctrl_q[`BCS_POS_POSTCHG_DIS];
    assign bridge_cfg.adaptive_gate_filter = ctrl_q[`BCS_POS_AGC_FILT];
    assign bridge_cfg.active_freewheel_detect = ctrl_q[`BCS_POS_FW_DETECT];
    assign bridge_cfg.hold_current_select = ctrl_q[`BCS_POS_HOLD_CUR];
    assign bridge_cfg.pump_freq_modulation = ctrl_q[`BCS_POS_FREQ_MOD];

endmodule
`default_nettype wire

// [common/bcs_regs.svh]
// Register offsets, field positions and reset values of the bridge control and scratch bank.
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

// ----------------------------------------------------------------
// Register addresses (7-bit serial register address)
// ----------------------------------------------------------------
`define BCS_ADDR_W 7
`define BCS_DATA_W 16
`define BCS_ADDR_GENERAL_BRIDGE_CONTROL 7'h10
`define BCS_ADDR_SCRATCH 7'h0F

// ----------------------------------------------------------------
// Bridge control field positions
// ----------------------------------------------------------------
`define BCS_POS_SYNC_FREQ 15
`define BCS_POS_RSVD_HI 14
`define BCS_POS_RSVD_LO 13
`define BCS_POS_UV_TH 12
`define BCS_POS_MOSFET_LEVEL_SELECT 11
`define BCS_POS_STAGE_AUTO 10
`define BCS_POS_OV_REC 9
`define BCS_POS_STEP_SIZE 8
`define BCS_POS_AGC_HI 7
`define BCS_POS_AGC_LO 6
`define BCS_POS_PUMP_EN 5
`define BCS_POS_POSTCHG_DIS 4
`define BCS_POS_AGC_FILT 3
`define BCS_POS_FW_DETECT 2
`define BCS_POS_HOLD_CUR 1
`define BCS_POS_FREQ_MOD 0

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define BCS_GENERAL_BRIDGE_CONTROL_RST 16'h0801
`define BCS_GENERAL_BRIDGE_CONTROL_WMASK 16'h9FFF
`define BCS_SCRATCH_RST 16'h0000
`define BCS_SCRATCH_WMASK 16'hFFFF

`endif

// [common/bcs_pkg.sv]
// Types shared by the bridge control and scratch register bank.
package bcs_pkg;

    typedef enum logic [1:0] {
        BCS_AGC_OFF,
        BCS_AGC_FIXED,
        BCS_AGC_ADAPT,
        BCS_AGC_ADAPT_ALT
    } bcs_agc_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] addr;
        logic [15:0] wdata;
    } bcs_req_t;

    typedef struct packed {
        logic ack;
        logic refused;
        logic unmapped;
        logic [15:0] rdata;
    } bcs_resp_t;

    typedef struct packed {
        logic sync_freq_select;
        logic pump_undervolt_threshold;
        logic mosfet_level_select;
        logic pump_stage_autoswitch;
        logic overvolt_recovery_enable;
        logic precurrent_step_size;
        bcs_agc_mode_t adaptive_gate_mode;
        logic pump_enable;
        logic postcharge_disable;
        logic adaptive_gate_filter;
        logic active_freewheel_detect;
        logic hold_current_select;
        logic pump_freq_modulation;
    } bcs_bridge_cfg_t;

    typedef struct packed {
        logic [15:0] value;
    } bcs_hold_state_t;

    typedef struct packed {
        bcs_resp_t resp;
    } bcs_top_state_t;

endpackage

// [hw/bcs_hold_reg.sv]
// One 16-bit host register with power-on, soft-reset, restart and write behaviour.
`timescale 1ns/1ps
`default_nettype none

module bcs_hold_reg
#(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RST_VAL = '0,
    parameter logic [WIDTH-1:0] WR_MASK = '1
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic restart,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] q
);
    import bcs_pkg::*;

    logic [WIDTH-1:0] val_r;
    logic [WIDTH-1:0] val_nxt;

    // ----------------------------------------------------------------
    // Next value
    // ----------------------------------------------------------------
    // Soft reset wins over restart, restart wins over a host write.
    // Restart clears only bits that cannot be written, the rest hold.
    always_comb
    begin
        val_nxt = val_r;
        if (soft_rst)
        begin
            val_nxt = RST_VAL;
        end
        else if (restart)
        begin
            val_nxt = val_r & WR_MASK;
        end
        else if (wr_en)
        begin
            val_nxt = wr_data & WR_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            val_r <= RST_VAL;
        end
        else
        begin
            val_r <= val_nxt;
        end
    end

    assign q = val_r;

endmodule
`default_nettype wire

// [test/bcs_top_assertions.sv]
// Port checker for the bridge control and scratch register bank.
`timescale 1ns/1ps
`default_nettype none
module bcs_top_assertions
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic restart,
    input wire logic normal_mode,
    input wire bcs_pkg::bcs_req_t req,
    input wire bcs_pkg::bcs_resp_t resp,
    input wire bcs_pkg::bcs_bridge_cfg_t bridge_cfg,
    input wire logic [15:0] scratch_value
);
    import bcs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic ctl;
    logic scr;
    assign ctl = req.addr == 7'h10;
    assign scr = req.addr == 7'h0F;
    sequence s_wr_ctl;
        req.valid && req.write && ctl && !soft_rst && !restart;
    endsequence
    sequence s_zero;
        resp.ack && resp.rdata == 16'h0000;
    endsequence
    property p_ack; req.valid |=> resp.ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_wr; s_wr_ctl |=> bridge_cfg == $past({req.wdata[15], req.wdata[12:0]}); endproperty
    a_wr: assert property (p_wr) else $error("ctrl write lost");
    property p_rd; req.valid && !req.write && ctl && !soft_rst
        |=> resp.rdata == {bridge_cfg[13], 2'b00, bridge_cfg[12:0]}; endproperty
    a_rd: assert property (p_rd) else $error("ctrl read wrong");
    property p_unmap; req.valid && !ctl && !scr |=> s_zero ##0 resp.unmapped; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped wrong");
    property p_refuse; req.valid && scr && !normal_mode && !soft_rst
        |=> s_zero ##0 resp.refused ##0 $stable(scratch_value); endproperty
    a_refuse: assert property (p_refuse) else $error("refusal wrong");
    property p_keep; !(req.valid && req.write && scr && normal_mode) && !soft_rst
        |=> $stable(scratch_value); endproperty
    a_keep: assert property (p_keep) else $error("scratch changed");
    property p_scr; req.valid && req.write && scr && normal_mode && !soft_rst
        |=> scratch_value == $past(req.wdata); endproperty
    a_scr: assert property (p_scr) else $error("scratch write lost");
    property p_soft; soft_rst |=> scratch_value == 16'h0000 && bridge_cfg == 14'h0801; endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    property p_rst; restart && !soft_rst && !req.valid |=> $stable(bridge_cfg); endproperty
    a_rst: assert property (p_rst) else $error("restart changed ctrl");
endmodule
bind bcs_top bcs_top_assertions chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .restart(restart), .normal_mode(normal_mode), .req(req),
    .resp(resp), .bridge_cfg(bridge_cfg), .scratch_value(scratch_value));
`default_nettype wire

// [test/bcs_host.sv]
// Host model that issues one-cycle register requests.
`timescale 1ns/1ps
`default_nettype none
module bcs_host
(
    input wire logic ref_clk,
    output bcs_pkg::bcs_req_t req,
    input wire bcs_pkg::bcs_resp_t resp
);
    import bcs_pkg::*;
    bcs_resp_t r;
    initial req = '0;
    // Released address and data are inverted so stale values never look valid.
    task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, w, a, d};
        @(posedge ref_clk);
        req <= '{1'b0, w, ~a, ~d};
        #1;
        r = resp;
    endtask
endmodule
`default_nettype wire

// [test/bcs_top_tb.sv]
// Self-checking bench for the bridge control and scratch register bank.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module bcs_top_tb;
    import bcs_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_rst = 1'b0;
    logic restart = 1'b0;
    logic normal_mode = 1'b1;
    bcs_req_t req;
    bcs_resp_t resp;
    bcs_bridge_cfg_t bridge_cfg;
    logic [15:0] scratch_value;
    logic [15:0] m;
    int miscompares = 0;
    int num_checks = 0;
    always #5 ref_clk = ~ref_clk;
    bcs_host host_u (.ref_clk(ref_clk), .req(req), .resp(resp));
    bcs_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .restart(restart), .normal_mode(normal_mode), .req(req), .resp(resp),
        .bridge_cfg(bridge_cfg), .scratch_value(scratch_value));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e, input string n);
        host_u.acc(1'b0, a, 16'h0000);
        chk(n, e, host_u.r.rdata);
    endtask
    function automatic logic [15:0] c16(input bcs_bridge_cfg_t c);
        return {c[13], 2'b00, c[12:0]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`BCS_ADDR_GENERAL_BRIDGE_CONTROL, 16'h0801, "ctrl reset");
        rd(`BCS_ADDR_SCRATCH, 16'h0000, "scratch reset");
        chk("cfg reset", 16'h0801, c16(bridge_cfg));
        $display("reset test done");
        for (int i = 0; i < 17; i++)
        begin
            m = (i == 16) ? 16'hFFFF : 16'h0001 << i;
            host_u.acc(1'b1, `BCS_ADDR_GENERAL_BRIDGE_CONTROL, m);
            chk("ctrl echo", m & 16'h9FFF, host_u.r.rdata);
            chk("cfg", m & 16'h9FFF, c16(bridge_cfg));
            rd(`BCS_ADDR_GENERAL_BRIDGE_CONTROL, m & 16'h9FFF, "ctrl read");
        end
        $display("ctrl test done");
        host_u.acc(1'b1, `BCS_ADDR_SCRATCH, 16'hA5C3);
        rd(`BCS_ADDR_SCRATCH, 16'hA5C3, "scratch read");
        @(posedge ref_clk);
        normal_mode <= 1'b0;
        host_u.acc(1'b1, `BCS_ADDR_SCRATCH, 16'h1234);
        chk("refused", 16'h0001, {15'h0000, host_u.r.refused});
        rd(`BCS_ADDR_SCRATCH, 16'h0000, "refused read");
        chk("scratch kept", 16'hA5C3, scratch_value);
        @(posedge ref_clk);
        normal_mode <= 1'b1;
        rd(7'h11, 16'h0000, "unmapped read");
        chk("unmapped", 16'h0001, {15'h0000, host_u.r.unmapped});
        $display("scratch test done");
        @(posedge ref_clk);
        restart <= 1'b1;
        @(posedge ref_clk);
        restart <= 1'b0;
        rd(`BCS_ADDR_GENERAL_BRIDGE_CONTROL, 16'h9FFF, "ctrl restart");
        rd(`BCS_ADDR_SCRATCH, 16'hA5C3, "scratch restart");
        @(posedge ref_clk);
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        rd(`BCS_ADDR_GENERAL_BRIDGE_CONTROL, 16'h0801, "ctrl soft");
        rd(`BCS_ADDR_SCRATCH, 16'h0000, "scratch soft");
        $display("reset modes test done");
        end_of_test();
    end
endmodule
`default_nettype wire
